//--- rtl/vpw_bus_config.sv
// vpw link configuration, time base, tx guard and fault flag logic
`include "vpw_consts.svh"
module vpw_bus_config
  import vpw_pkg::*;
#(
  parameter int BRK_TICKS = `BRK_TICKS,
  parameter int TTO_TICKS = `TTO_TICKS,
  parameter int MAX_BYTES = `MAX_FRAME_BYTES
) (
  // clock, reset, enable
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  // bus pins through transceiver
  input  wire logic        busRxIn,
  output      logic        busTxOut,
  // symbol engine side
  input  wire logic        txDrive,
  input  wire logic        sendBreak,
  input  wire logic        txLastBitEnd,
  input  wire logic        txMoreExpected,
  input  wire logic        txOpPending,
  input  wire logic        txAbortEv,
  input  wire logic        rxByteValid,
  input  wire logic [7:0]  rxByteIn,
  input  wire logic        rxSof,
  input  wire logic        rxEofValid,
  input  wire logic        rxBreakPresent,
  input  wire logic        crcErrEv,
  input  wire logic        frameErrEv,
  input  wire logic        bitErrEv,
  // engine configuration and status
  output      logic        tick,
  output      logic        quadRate,
  output      logic [4:0]  loopDelay,
  output      logic [7:0]  nodeAddr,
  output      logic        rxSeen,
  output      logic        linkActive,
  output      logic        rxHalted,
  output      logic        txFlush,
  output      logic        sendInvCrc
);
  localparam int TTO_Q = TTO_TICKS * `QUAD_FACTOR;
  localparam int CW    = $clog2(TTO_Q + 1);
  localparam int BW    = $clog2(MAX_BYTES + 2);
  localparam logic [CW-1:0] TTO_N  = CW'(TTO_TICKS - 1);
  localparam logic [CW-1:0] TTO_QN = CW'(TTO_Q - 1);
  localparam logic [CW-1:0] BRK_N  = CW'(BRK_TICKS - 1);
  localparam logic [CW-1:0] BRK_QN = CW'(BRK_TICKS * `QUAD_FACTOR - 1);
  localparam logic [BW-1:0] MAXB   = BW'(MAX_BYTES);
  // register file and bus slave state
  freq_sel_t   freq_r,    freq_nxt;
  link_ctrl_t  ctrl_r,    ctrl_nxt;
  logic [7:0]  addr_r,    addr_nxt;
  logic [7:0]  rx_byte_reg_r,  rx_byte_reg_nxt;
  logic        unread_r,  unread_nxt;
  logic [31:0] prdata_r,  prdata_nxt;
  logic        pready_r,  pready_nxt;
  logic        pslverr_r, pslverr_nxt;
  logic        divRestart;
  logic        rdFault;
  logic        rdRx;
  logic [7:0]  idx;
  logic        setup;
  logic        access;
  // time base, tx guard and fault state
  logic [5:0]    divCnt_r,  divCnt_nxt;
  logic          tick_r,    tick_nxt;
  tx_state_t     st_r,      st_nxt;
  logic [CW-1:0] brkCnt_r,  brkCnt_nxt;
  logic [CW-1:0] ttoCnt_r,  ttoCnt_nxt;
  logic          txOut_r,   txOut_nxt;
  fault_t        fault_r,   fault_nxt;
  fault_t        pend_r,    pend_nxt;
  fault_t        ev;
  fault_t        clr;
  logic          errCond_r, errCond_nxt;
  logic [BW-1:0] bytes_r,   bytes_nxt;
  logic          flush_r,   flush_nxt;
  logic          invCrc_r,  invCrc_nxt;
  logic          rxSeen_r,  rxSeen_nxt;
  logic          linkOn;
  logic          ttoHit;
  logic          lenErr;
  logic          errNow;
  assign idx    = paddr[9:2];
  assign setup  = psel & ~penable;
  assign access = psel & penable & pready_r;
  assign linkOn = ctrl_r.en & ~ctrl_r.freeze;

  // register file with a zero-wait apb answer prepared in setup
  always_comb begin
    freq_nxt    = freq_r;
    ctrl_nxt    = ctrl_r;
    addr_nxt    = addr_r;
    prdata_nxt  = prdata_r;
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    divRestart  = 1'b0;
    rdFault     = 1'b0;
    rdRx        = 1'b0;
    if (setup) begin
      pready_nxt = 1'b1;
      prdata_nxt = 32'h0000_0000;
      if (paddr[11:10] != 2'b00) begin
        pslverr_nxt = 1'b1;
      end else begin
        unique case (idx)
          `IDX_FREQ:   prdata_nxt[7:0] = freq_r;
          `IDX_CTRL:   prdata_nxt[7:0] = ctrl_r;
          `IDX_PADDR:  prdata_nxt[7:0] = addr_r;
          `IDX_FAULT:  prdata_nxt[7:0] = fault_r;
          `IDX_RXBYTE: prdata_nxt[7:0] = rx_byte_reg_r;
          default:     pslverr_nxt     = 1'b1;
        endcase
      end
    end
    if (access && !pslverr_r) begin
      if (pwrite) begin
        unique case (idx)
          `IDX_FREQ: begin
            freq_nxt      = pwdata[7:0];
            freq_nxt.rsvd = 1'b0;
            divRestart    = 1'b1;
          end
          `IDX_CTRL: begin
            ctrl_nxt    = pwdata[7:0];
            // enable only takes once freeze was already low
            ctrl_nxt.en = pwdata[7] & ~pwdata[6] & ~ctrl_r.freeze;
          end
          `IDX_PADDR: addr_nxt = pwdata[7:0];
          default: ;
        endcase
      end else begin
        rdFault = (idx == `IDX_FAULT);
        rdRx    = (idx == `IDX_RXBYTE);
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      freq_r    <= `RST_FREQ;
      ctrl_r    <= `RST_CTRL;
      addr_r    <= `RST_PADDR;
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (ce) begin
      freq_r    <= freq_nxt;
      ctrl_r    <= ctrl_nxt;
      addr_r    <= addr_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // 1 MHz tick and tx guard: break timing and stuck-active timeout
  always_comb begin
    divCnt_nxt = divCnt_r + 6'h01;
    tick_nxt   = 1'b0;
    if (ctrl_r.freeze || divRestart) begin
      divCnt_nxt = 6'h00;
    end else if (divCnt_r >= freq_r.div) begin
      divCnt_nxt = 6'h00;
      tick_nxt   = 1'b1;
    end
    st_nxt     = st_r;
    brkCnt_nxt = brkCnt_r;
    ttoCnt_nxt = ttoCnt_r;
    ttoHit     = 1'b0;
    if (txOut_r && tick_r) begin
      ttoCnt_nxt = ttoCnt_r + CW'(1);
      ttoHit = (ttoCnt_r >= (freq_r.quad ? TTO_QN : TTO_N));
    end else if (!txOut_r) begin
      ttoCnt_nxt = '0;
    end
    unique case (st_r)
      TX_IDLE: begin
        brkCnt_nxt = '0;
        if (sendBreak) st_nxt = TX_BREAK;
      end
      TX_BREAK: begin
        if (tick_r) begin
          brkCnt_nxt = brkCnt_r + CW'(1);
          if (brkCnt_r >= (freq_r.quad ? BRK_QN : BRK_N)) begin
            st_nxt = TX_IDLE;
          end
        end
      end
      TX_TRIP: ;
    endcase
    if (ttoHit) st_nxt = TX_TRIP;
    if (!linkOn) begin
      st_nxt     = TX_IDLE;
      ttoCnt_nxt = '0;
    end
    // output passive unless enabled and not tripped
    txOut_nxt = linkOn &&
                (st_nxt == TX_BREAK || (st_nxt == TX_IDLE && txDrive));
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      divCnt_r <= 6'h00;
      tick_r   <= 1'b0;
      st_r     <= TX_IDLE;
      brkCnt_r <= '0;
      ttoCnt_r <= '0;
      txOut_r  <= 1'b0;
    end else if (ce) begin
      divCnt_r <= divCnt_nxt;
      tick_r   <= tick_nxt;
      st_r     <= st_nxt;
      brkCnt_r <= brkCnt_nxt;
      ttoCnt_r <= ttoCnt_nxt;
      txOut_r  <= txOut_nxt;
    end
  end

  // fault flags, frame length check and rx byte holding
  always_comb begin
    lenErr = rxByteValid & ~ctrl_r.frame_length_check_disable & (bytes_r == MAXB);
    ev      = '0;
    ev.tdf  = txLastBitEnd & txMoreExpected & ~txOpPending;
    ev.rx_overflow_flag = rxByteValid & unread_r;
    ev.tx_request_aborted_flag  = txAbortEv;
    ev.rx_break_flag = rxBreakPresent;
    ev.crc  = crcErrEv;
    ev.invalid_frame_flag  = frameErrEv | lenErr;
    ev.invalid_bit_flag  = bitErrEv;
    if (!linkOn || st_r == TX_TRIP) ev = '0;
    clr      = rdFault ? fault_t'(prdata_r[7:0]) : '0;
    clr.tx_timeout_flag  = 1'b0;
    clr.rx_break_flag = clr.rx_break_flag & ~rxBreakPresent;
    // pending events wait for the next tick; sets beat a clear
    pend_nxt  = pend_r | ev;
    fault_nxt = fault_r & ~clr;
    errNow    = 1'b0;
    if (tick_r) begin
      fault_nxt = fault_nxt | pend_r | ev;
      pend_nxt  = '0;
      errNow    = |{pend_nxt.rx_break_flag, pend_r.rx_break_flag, pend_r.crc, pend_r.invalid_frame_flag,
                    pend_r.invalid_bit_flag, ev.rx_break_flag, ev.crc, ev.invalid_frame_flag, ev.invalid_bit_flag};
    end
    if (ttoHit) fault_nxt.tx_timeout_flag = 1'b1;
    errCond_nxt = (errCond_r | errNow) & ~rxEofValid;
    bytes_nxt   = bytes_r;
    if (rxSof || rxEofValid) begin
      bytes_nxt = '0;
    end else if (rxByteValid && bytes_r <= MAXB) begin
      bytes_nxt = bytes_r + BW'(1);
    end
    rx_byte_reg_nxt = rxByteValid ? rxByteIn : rx_byte_reg_r;
    unread_nxt = rxByteValid | (unread_r & ~rdRx);
    flush_nxt  = (ctrl_r.en & ~ctrl_nxt.en) | (errNow & ~errCond_r);
    invCrc_nxt = ev.tdf;
    rxSeen_nxt = linkOn & busRxIn;
    if (!linkOn) begin
      fault_nxt   = '0;
      pend_nxt    = '0;
      errCond_nxt = 1'b0;
      bytes_nxt   = '0;
      unread_nxt  = 1'b0;
      rx_byte_reg_nxt  = rx_byte_reg_r;
      invCrc_nxt  = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fault_r   <= `RST_FAULT;
      pend_r    <= '0;
      errCond_r <= 1'b0;
      bytes_r   <= '0;
      rx_byte_reg_r  <= 8'h00;
      unread_r  <= 1'b0;
      flush_r   <= 1'b0;
      invCrc_r  <= 1'b0;
      rxSeen_r  <= 1'b0;
    end else if (ce) begin
      fault_r   <= fault_nxt;
      pend_r    <= pend_nxt;
      errCond_r <= errCond_nxt;
      bytes_r   <= bytes_nxt;
      rx_byte_reg_r  <= rx_byte_reg_nxt;
      unread_r  <= unread_nxt;
      flush_r   <= flush_nxt;
      invCrc_r  <= invCrc_nxt;
      rxSeen_r  <= rxSeen_nxt;
    end
  end

  assign prdata     = prdata_r;
  assign pready     = pready_r;
  assign pslverr    = pslverr_r;
  assign busTxOut   = txOut_r;
  assign tick       = tick_r;
  assign quadRate   = freq_r.quad;
  assign loopDelay  = ctrl_r.dly;
  assign nodeAddr   = addr_r;
  assign rxSeen     = rxSeen_r;
  assign linkActive = ctrl_r.en & ~ctrl_r.freeze;
  assign rxHalted   = errCond_r;
  assign txFlush    = flush_r;
  assign sendInvCrc = invCrc_r;
endmodule

//--- shared/vpw_consts.svh
// register indices, reset values and timing figures of the vpw config block
`ifndef VPW_CONSTS_SVH
`define VPW_CONSTS_SVH
`define IDX_FREQ       8'hF4
`define IDX_CTRL       8'hF5
`define IDX_PADDR      8'hF6
`define IDX_FAULT      8'hF7
`define IDX_RXBYTE     8'hF8
`define RST_FREQ       8'h00
`define RST_CTRL       8'h40
`define RST_PADDR      8'h00
`define RST_FAULT      8'h00
`define TICK_US        1
`define BRK_TIME_US    300
`define TTO_TIME_US    1000
`define BRK_TICKS      (`BRK_TIME_US / `TICK_US)
`define TTO_TICKS      (`TTO_TIME_US / `TICK_US)
`define QUAD_FACTOR    4
`define MAX_FRAME_BYTES 12
`endif

//--- shared/vpw_pkg.sv
// register layouts and state types of the vpw config block
package vpw_pkg;
  typedef struct packed {
    logic       quad;
    logic       rsvd;
    logic [5:0] div;
  } freq_sel_t;
  typedef struct packed {
    logic       en;
    logic       freeze;
    logic       frame_length_check_disable;
    logic [4:0] dly;
  } link_ctrl_t;
  typedef struct packed {
    logic tx_timeout_flag;
    logic tdf;
    logic rx_overflow_flag;
    logic tx_request_aborted_flag;
    logic rx_break_flag;
    logic crc;
    logic invalid_frame_flag;
    logic invalid_bit_flag;
  } fault_t;
  typedef enum logic [2:0] {
    TX_IDLE  = 3'b001,
    TX_BREAK = 3'b010,
    TX_TRIP  = 3'b100
  } tx_state_t;
endpackage

//--- tb/test_vpw_bus_config.sv
// self-checking bench of the vpw config block
`include "vpw_consts.svh"
module test_vpw_bus_config;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BRKT = 4;
  localparam logic [11:0] AR = {2'h0, `IDX_FREQ, 2'h0};
  localparam logic [11:0] AC = {2'h0, `IDX_CTRL, 2'h0};
  localparam logic [11:0] AA = {2'h0, `IDX_PADDR, 2'h0};
  localparam logic [11:0] AE = {2'h0, `IDX_FAULT, 2'h0};
  localparam logic [7:0] EVF [5] = '{8'h01, 8'h02, 8'h04, 8'h10, 8'h40};
  logic        clk, resetn, psel, penable, pwrite, txDrive, fo, ce, brk;
  logic        pready, pslverr, err, busRxIn, busTxOut, tick, opPend;
  logic        quadRate, rxSeen, linkActive, rxHalted, txFlush, sendInvCrc;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [8:0]  ev;
  logic [7:0]  rxByteIn, nodeAddr;
  logic [4:0]  loopDelay;
  int          n_fail, n_compared, cnt;
  vpw_bus_config #(.BRK_TICKS(BRKT), .TTO_TICKS(10)) i_vpw_bus_config (
    .clk, .resetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .busRxIn, .busTxOut, .txDrive,
    .sendBreak(ev[8]), .txLastBitEnd(ev[4]), .txMoreExpected(1'b1),
    .txOpPending(opPend), .txAbortEv(ev[3]), .rxByteValid(ev[5]),
    .rxByteIn, .rxSof(ev[7]), .rxEofValid(ev[6]), .rxBreakPresent(brk),
    .crcErrEv(ev[2]), .frameErrEv(ev[1]), .bitErrEv(ev[0]), .tick,
    .quadRate, .loopDelay, .nodeAddr, .rxSeen, .linkActive, .rxHalted,
    .txFlush, .sendInvCrc
  );
  vpw_bus_node i_vpw_bus_node (
    .clk, .txOut(busTxOut), .foreign(fo), .rxIn(busRxIn)
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic report_and_stop;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_fail++;
      report_and_stop;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic pulse(input int b);
    @(posedge clk);
    ev <= 9'h1 << b;
    @(posedge clk);
    ev <= 9'h0;
  endtask
  initial begin
    {resetn, psel, penable, pwrite, txDrive, fo, ev, rxByteIn} = '0;
    {brk, opPend} = '0;
    ce = 1'b1;
    {paddr, pwdata} = '0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    apb(0, AR, 0);
    check("freq", rd, `RST_FREQ);
    apb(0, AC, 0);
    check("ctrl", rd, `RST_CTRL);
    apb(0, AE, 0);
    check("fault", rd, `RST_FAULT);
    apb(0, 12'h3E4, 0);
    check("slverr", err, 1);
    apb(0, 12'hBD0, 0);
    check("slverr high", err, 1);
    fo <= 1'b1;
    apb(1, AC, 8'h80);
    check("rx off", rxSeen, 0);
    apb(0, AC, 0);
    check("ctrl one write", rd, 0);
    apb(1, AC, 8'h80);
    apb(0, AC, 0);
    check("ctrl on", rd, 8'h80);
    check("rx on", rxSeen, 1);
    fo <= 1'b0;
    apb(1, AA, 8'hA5);
    cyc(1);
    check("addr", nodeAddr, 8'hA5);
    apb(1, AC, 8'h9F);
    cyc(1);
    check("delay", loopDelay, 5'h1F);
    apb(1, AE, 8'hFF);
    apb(0, AE, 0);
    check("fault ro", rd, 0);
    for (int i = 0; i < 5; i++) begin
      pulse(i);
      cyc(1);
      check("inv crc", sendInvCrc, i == 4);
      check("flush", txFlush, i < 3);
      check("halt", rxHalted, i < 3);
      cyc(3);
      apb(0, AE, 0);
      check("flag", rd, EVF[i]);
      apb(0, AE, 0);
      check("flag clear", rd, 0);
      pulse(6);
    end
    for (int n = 0; n < 2; n++) begin
      apb(1, AC, n ? 8'hA0 : 8'h80);
      pulse(7);
      for (int k = 0; k < 13; k++) begin
        rxByteIn <= 8'(k);
        pulse(5);
      end
      cyc(4);
      apb(0, AE, 0);
      check("frame", rd, n ? 8'h20 : 8'h22);
      apb(0, 12'h3E0, 0);
      check("rx byte", rd, 8'h0C);
      pulse(6);
    end
    brk <= 1'b1;
    cyc(3);
    apb(0, AE, 0);
    check("break flag", rd, 8'h08);
    apb(0, AE, 0);
    check("break kept", rd, 8'h08);
    brk <= 1'b0;
    apb(0, AE, 0);
    check("break last", rd, 8'h08);
    apb(0, AE, 0);
    check("break gone", rd, 0);
    pulse(6);
    opPend <= 1'b1;
    pulse(4);
    cyc(3);
    apb(0, AE, 0);
    check("op queued", rd, 0);
    opPend <= 1'b0;
    ce <= 1'b0;
    pulse(0);
    cyc(2);
    ce <= 1'b1;
    apb(0, AE, 0);
    check("frozen", rd, 0);
    apb(1, AR, 8'h80);
    cyc(1);
    check("quad", quadRate, 1);
    apb(0, AR, 0);
    check("freq kept", rd, 8'h80);
    pulse(8);
    cnt = 0;
    repeat (40) begin
      @(posedge clk);
      if (busTxOut === 1'b1) cnt++;
    end
    check("break", 32'(cnt), 4 * BRKT);
    apb(1, AR, 8'h00);
    txDrive <= 1'b1;
    cyc(30);
    check("tx killed", busTxOut, 0);
    apb(0, AE, 0);
    check("timeout", rd, 8'h80);
    apb(0, AE, 0);
    check("timeout kept", rd, 8'h80);
    txDrive <= 1'b0;
    apb(1, AC, 8'h00);
    apb(0, AE, 0);
    check("timeout off", rd, 0);
    apb(1, AC, 8'h80);
    apb(1, AC, 8'hC0);
    apb(0, AC, 0);
    check("freeze", rd, 8'h40);
    check("link", linkActive, 0);
    resetn <= 1'b0;
    cyc(2);
    check("addr reset", nodeAddr, `RST_PADDR);
    resetn <= 1'b1;
    report_and_stop;
  end
endmodule

//--- tb/vpw_bus_config_properties.sv
// port checker of the vpw config block
module vpw_bus_config_checker
  import vpw_pkg::*;
#(
  parameter int TTO_TICKS = 1000
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // link
  input wire logic        busTxOut,
  input wire logic        tick,
  input wire logic        quadRate,
  input wire logic [4:0]  loopDelay,
  input wire logic [7:0]  nodeAddr,
  input wire logic        rxSeen,
  input wire logic        linkActive,
  input wire logic        rxHalted,
  input wire logic        txFlush,
  input wire logic        rxEofValid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic        acc;
  logic [15:0] hiTicks_r;
  logic [15:0] hiTicks_nxt;
  assign acc = psel && penable && pready;
  // ticks of uninterrupted active output
  always_comb begin
    hiTicks_nxt = busTxOut ? hiTicks_r + 16'(tick) : 16'h0;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) hiTicks_r <= 16'h0;
    else hiTicks_r <= hiTicks_nxt;
  end
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_err; acc && paddr[11:10] != 2'h0 |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("no slave error");
  property p_txoff; !linkActive |=> !busTxOut; endproperty
  a_txoff: assert property (p_txoff) else $error("tx on");
  property p_rxoff; !linkActive |=> !rxSeen; endproperty
  a_rxoff: assert property (p_rxoff) else $error("rx on");
  property p_flush; $fell(linkActive) |-> ##[0:2] txFlush; endproperty
  a_flush: assert property (p_flush) else $error("no flush");
  property p_foff;
    (!linkActive)[*3] ##0 (acc && !pwrite && paddr == 12'h3DC)
      |-> prdata == 32'h0;
  endproperty
  a_foff: assert property (p_foff) else $error("flags set");
  property p_quad;
    acc && pwrite && paddr == 12'h3D0 |=> quadRate == $past(pwdata[7]);
  endproperty
  a_quad: assert property (p_quad) else $error("bad quad");
  property p_dly;
    acc && pwrite && paddr == 12'h3D4 |=> loopDelay == $past(pwdata[4:0]);
  endproperty
  a_dly: assert property (p_dly) else $error("bad delay");
  property p_addr;
    acc && pwrite && paddr == 12'h3D8 |=> nodeAddr == $past(pwdata[7:0]);
  endproperty
  a_addr: assert property (p_addr) else $error("bad address");
  property p_halt;
    rxHalted && !rxEofValid && linkActive |=> rxHalted || !linkActive;
  endproperty
  a_halt: assert property (p_halt) else $error("halt lost");
  property p_tto; hiTicks_r <= 16'(4 * TTO_TICKS + 2); endproperty
  a_tto: assert property (p_tto) else $error("tx too long");
  c_err: cover property (acc && pslverr);
  c_off: cover property ($fell(linkActive));
  c_halt: cover property (rxHalted ##1 !rxHalted);
endmodule

bind vpw_bus_config vpw_bus_config_checker #(.TTO_TICKS(TTO_TICKS))
  i_vpw_bus_config_checker (
  .clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .busTxOut, .tick, .quadRate, .loopDelay, .nodeAddr,
  .rxSeen, .linkActive, .rxHalted, .txFlush, .rxEofValid
);

//--- tb/vpw_bus_node.sv
// bus node model: transceiver loop back plus a foreign transmitter
module vpw_bus_node #(
  parameter int LOOP = 3
) (
  // clock
  input  wire logic clk,
  // bus side
  input  wire logic txOut,
  input  wire logic foreign,
  output      logic rxIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [LOOP-1:0] dly_r = '0;
  always_ff @(posedge clk) begin
    dly_r <= {dly_r[LOOP-2:0], txOut};
  end
  // passive bus rests low, any active driver wins
  assign rxIn = dly_r[LOOP-1] | foreign;
endmodule
